// ---- inc/cfq_defines.svh ----
`ifndef CFQ_DEFINES_SVH
`define CFQ_DEFINES_SVH
// Channel count: channel 0 is the transmit queue, 1..7 the FIFOs
`define CFQ_NCH 8
// Register select, reg_addr[1:0]; channel is reg_addr[4:2]
`define CFQ_OFS_CONH 2'h0
`define CFQ_OFS_CONL 2'h1
`define CFQ_OFS_STA 2'h2
// Control high fields (lsb)
`define CFQ_F_PLS 13
`define CFQ_F_DEP 8
`define CFQ_F_RTY 5
`define CFQ_F_PRI 0
// Control low bits
`define CFQ_B_CLR 10
`define CFQ_B_SEND 9
`define CFQ_B_ADV 8
`define CFQ_B_DIR 7
// Status bits; bits 4..0 share positions with the enables
`define CFQ_B_ABT 7
`define CFQ_B_ARB 6
`define CFQ_B_ERR 5
`define CFQ_B_EXH 4
`define CFQ_B_OVF 3
// Reset values
`define CFQ_RST_PLS 3'h0
`define CFQ_RST_DEP 5'h00
`define CFQ_RST_RTY 2'h3
`define CFQ_RST_PRI 5'h00
`define CFQ_RST_CLR_Q 1'b0
`define CFQ_RST_CLR_F 1'b1
// Writable enables: queue has only bits 4, 2, 0
`define CFQ_IE_MASK_Q 7'h15
`define CFQ_IE_MASK_F 7'h7f
// Configuration mode code
`define CFQ_MODE_CFG 3'h4
// Retry codes
`define CFQ_RTY_NONE 2'h0
`define CFQ_RTY_THREE 2'h1
`define CFQ_FAIL_THREE 2'h2
// Payload bytes per size code
`define CFQ_PL0 7'h08
`define CFQ_PL1 7'h0c
`define CFQ_PL2 7'h10
`define CFQ_PL3 7'h14
`define CFQ_PL4 7'h18
`define CFQ_PL5 7'h20
`define CFQ_PL6 7'h30
`define CFQ_PL7 7'h40
`endif

// ---- inc/cfq_pkg.sv ----
`include "cfq_defines.svh"
package cfq_pkg;
  typedef logic [15:0] cfq_word_t;
  typedef enum logic [1:0] {
    CFQ_R_CONH = `CFQ_OFS_CONH,
    CFQ_R_CONL = `CFQ_OFS_CONL,
    CFQ_R_STA = `CFQ_OFS_STA
  } cfq_reg_t;
  function automatic logic [6:0] cfq_payload_bytes(input logic [2:0] sel);
    logic [6:0] b;
    b = `CFQ_PL0;
    case (sel)
      3'h1: b = `CFQ_PL1;
      3'h2: b = `CFQ_PL2;
      3'h3: b = `CFQ_PL3;
      3'h4: b = `CFQ_PL4;
      3'h5: b = `CFQ_PL5;
      3'h6: b = `CFQ_PL6;
      3'h7: b = `CFQ_PL7;
      default: b = `CFQ_PL0;
    endcase
    return b;
  endfunction : cfq_payload_bytes
endpackage : cfq_pkg

// ---- design/cfq_ptr.sv ----
`timescale 1ns/100ps
// Head, tail and occupancy of one message ring
module cfq_ptr (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic [4:0] depth_sel,
  input wire logic push,
  input wire logic pop,
  output logic [4:0] head_q,
  output logic [4:0] tail_q,
  output logic [5:0] count_q,
  output logic empty,
  output logic full
);
  wire logic [5:0] depth = {1'b0, depth_sel} + 6'h01;
  wire logic do_push = push & ~full;
  wire logic do_pop = pop & ~empty;
  wire logic [4:0] head_inc = (head_q == depth_sel) ? 5'h00 : head_q + 5'h01;
  wire logic [4:0] tail_inc = (tail_q == depth_sel) ? 5'h00 : tail_q + 5'h01;

  assign empty = (count_q == 6'h00);
  assign full = (count_q >= depth);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || clear) begin
      head_q <= 5'h00;
      tail_q <= 5'h00;
      count_q <= 6'h00;
    end else begin
      if (do_push) head_q <= head_inc;
      if (do_pop) tail_q <= tail_inc;
      if (do_push && !do_pop) count_q <= count_q + 6'h01;
      else if (do_pop && !do_push) count_q <= count_q - 6'h01;
    end
  end
endmodule : cfq_ptr

// ---- design/cfq_pick.sv ----
`timescale 1ns/100ps
// Highest priority pending channel; ties go to the lower channel
module cfq_pick (
  input wire logic [7:0] pend,
  input wire logic [39:0] pri,
  output logic valid,
  output logic [2:0] chan
);
  logic [4:0] best;
  always_comb begin
    valid = 1'b0;
    chan = 3'h0;
    best = 5'h00;
    for (int i = 0; i < 8; i++) begin
      if (pend[i] && (!valid || pri[i*5 +: 5] > best)) begin
        valid = 1'b1;
        chan = 3'(i);
        best = pri[i*5 +: 5];
      end
    end
  end
endmodule : cfq_pick

// ---- design/cfq_ctrl.sv ----
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "cfq_defines.svh"
// How it works
// - Clear request resets ring, then self-clears
// - Send request starts; clears when ring drained
// - Writing zero over set send requests abort
// - Receive rings ignore send request writes
// - Transmit advance moves head by one
// - Receive advance moves tail by one
// - Direction bit picks transmit/receive; queue fixed
// - Remote request sets send when enabled
// - Timestamp capture pulses only when enabled
// - Size code maps to 8..64 payload bytes
// - Depth is depth field plus one
// - Retry field limits attempts under global enable
// - Higher priority field transmits first
// - Size and depth writable only in configuration
// - Index shows next message slot
// - Aborted bit: one aborted, zero completed
// - Lost arbitration and bus error reported
// - Aborted bit changes only at end, reset or clear request
// - Exhausted flag sticky until software clears
// - Empty and not-full flags reset to one
// - Overflow enable gates overflow interrupt
module cfq_ctrl
  import cfq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [2:0] operating_mode_sel,
  input wire logic retry_limit_enable,
  input wire logic [7:0] eng_tx_done,
  input wire logic [7:0] eng_abort_done,
  input wire logic [7:0] eng_attempt_fail,
  input wire logic [7:0] eng_lost_arb,
  input wire logic [7:0] eng_bus_err,
  input wire logic [7:0] eng_rx_store,
  input wire logic [7:0] eng_rx_rtr,
  output logic tx_valid,
  output logic [2:0] tx_chan,
  output logic [4:0] tx_index,
  output logic [6:0] tx_payload_bytes,
  output logic [7:0] abort_req,
  output logic [7:0] rx_ts_capture,
  output logic irq
);
  wire cfq_reg_t reg_sel = cfq_reg_t'(reg_addr[1:0]);
  wire logic cfg_mode = (operating_mode_sel == `CFQ_MODE_CFG);

  cfq_word_t conh_w [8];
  cfq_word_t conl_w [8];
  cfq_word_t sta_w [8];
  wire logic [4:0] idx_w [8];
  wire logic [2:0] pls_w [8];
  wire logic [7:0] pend_w;
  wire logic [7:0] irq_w;
  wire logic [7:0] ts_w;
  wire logic [39:0] pri_w;

  for (genvar g = 0; g < `CFQ_NCH; g++) begin : g_ch
    localparam logic IS_Q = (g == 0);
    localparam logic [6:0] IE_MASK = IS_Q ? `CFQ_IE_MASK_Q : `CFQ_IE_MASK_F;

    logic [2:0] pls_q;
    logic [4:0] dep_q;
    logic [1:0] rty_q;
    logic [4:0] pri_q;
    logic clr_q;
    logic send_q;
    logic abort_q;
    logic dir_q;
    logic [6:0] ie_q;
    logic abt_q;
    logic arb_q;
    logic err_q;
    logic arb_seen_q;
    logic err_seen_q;
    logic exh_q;
    logic ovf_q;
    logic ts_q;
    logic [1:0] fail_q;
    logic [4:0] head;
    logic [4:0] tail;
    logic [5:0] count;
    logic empty;
    logic full;

    wire logic hit = (reg_addr[4:2] == 3'(g));
    wire logic wr_h = reg_wr & hit & (reg_sel == CFQ_R_CONH);
    wire logic wr_l = reg_wr & hit & (reg_sel == CFQ_R_CONL);
    wire logic wr_s = reg_wr & hit & (reg_sel == CFQ_R_STA);

    wire logic is_tx = IS_Q | dir_q;

    wire logic done = eng_tx_done[g] & is_tx;
    wire logic abd = eng_abort_done[g] & is_tx;
    wire logic fail = eng_attempt_fail[g] & is_tx;
    wire logic rty_end = (rty_q == `CFQ_RTY_NONE) |
                         ((rty_q == `CFQ_RTY_THREE) & (fail_q == `CFQ_FAIL_THREE));
    wire logic exhaust = fail & retry_limit_enable & rty_end;
    wire logic finish = done | abd | exhaust;
    wire logic drained = done & (count == 6'h01);

    wire logic adv = wr_l & reg_wdata[`CFQ_B_ADV];
    wire logic push = is_tx ? adv : (eng_rx_store[g] & ~clr_q);
    wire logic pop = is_tx ? done : adv;

    wire logic rtr_hit = ~IS_Q & is_tx & ie_q[6] & eng_rx_rtr[g];
    wire logic send_set = (wr_l & reg_wdata[`CFQ_B_SEND] & is_tx) | rtr_hit;
    wire logic send_clr = drained | abd | exhaust | clr_q;
    wire logic abort_set = wr_l & ~reg_wdata[`CFQ_B_SEND] & send_q & is_tx;
    wire logic ovf_set = ~IS_Q & ~is_tx & eng_rx_store[g] & full;

    wire logic [5:0] depth = {1'b0, dep_q} + 6'h01;
    wire logic [6:0] cnt2 = {count, 1'b0};
    wire logic half = is_tx ? (cnt2 <= {1'b0, depth}) : (cnt2 >= {1'b0, depth});
    wire logic [4:0] flags = {exh_q, ovf_q & ~is_tx,
                              is_tx ? empty : full,
                              ~IS_Q & half,
                              is_tx ? ~full : ~empty};

    cfq_ptr u_ptr (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clear(clr_q),
      .depth_sel(dep_q),
      .push(push),
      .pop(pop),
      .head_q(head),
      .tail_q(tail),
      .count_q(count),
      .empty(empty),
      .full(full)
    );

    // Configuration fields
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        pls_q <= `CFQ_RST_PLS;
        dep_q <= `CFQ_RST_DEP;
        rty_q <= `CFQ_RST_RTY;
        pri_q <= `CFQ_RST_PRI;
      end else if (wr_h) begin
        if (cfg_mode) begin
          pls_q <= reg_wdata[`CFQ_F_PLS +: 3];
          dep_q <= reg_wdata[`CFQ_F_DEP +: 5];
        end
        rty_q <= reg_wdata[`CFQ_F_RTY +: 2];
        pri_q <= reg_wdata[`CFQ_F_PRI +: 5];
      end
    end

    // Enables and direction
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        ie_q <= 7'h00;
        dir_q <= 1'b0;
      end else if (wr_l) begin
        ie_q <= reg_wdata[6:0] & IE_MASK;
        if (!IS_Q) dir_q <= reg_wdata[`CFQ_B_DIR];
      end
    end

    // Clear request holds one cycle while the ring resets
    always_ff @(posedge sys_clk) begin
      if (sys_rst) clr_q <= IS_Q ? `CFQ_RST_CLR_Q : `CFQ_RST_CLR_F;
      else clr_q <= wr_l & reg_wdata[`CFQ_B_CLR];
    end

    // Send and abort requests; a set wins over a clear
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        send_q <= 1'b0;
        abort_q <= 1'b0;
      end else begin
        send_q <= send_set | (send_q & ~send_clr);
        abort_q <= abort_set | (abort_q & ~(finish | clr_q));
      end
    end

    // Completion status
    always_ff @(posedge sys_clk) begin
      if (sys_rst || clr_q) begin
        abt_q <= 1'b0;
        arb_q <= 1'b0;
        err_q <= 1'b0;
        arb_seen_q <= 1'b0;
        err_seen_q <= 1'b0;
        fail_q <= 2'h0;
      end else if (finish) begin
        abt_q <= abd | exhaust;
        arb_q <= arb_seen_q | eng_lost_arb[g];
        err_q <= err_seen_q | eng_bus_err[g];
        arb_seen_q <= 1'b0;
        err_seen_q <= 1'b0;
        fail_q <= 2'h0;
      end else begin
        arb_seen_q <= arb_seen_q | (eng_lost_arb[g] & is_tx);
        err_seen_q <= err_seen_q | (eng_bus_err[g] & is_tx);
        if (fail) fail_q <= fail_q + 2'h1;
      end
    end

    // Sticky flags: write zero clears, event set wins
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        exh_q <= 1'b0;
        ovf_q <= 1'b0;
      end else begin
        exh_q <= exhaust | (exh_q & ~(wr_s & ~reg_wdata[`CFQ_B_EXH]));
        ovf_q <= ovf_set | (ovf_q & ~(wr_s & ~reg_wdata[`CFQ_B_OVF]));
      end
    end

    // Timestamp capture pulse
    always_ff @(posedge sys_clk) begin
      if (sys_rst) ts_q <= 1'b0;
      else ts_q <= push & ~is_tx & ~full & ie_q[5];
    end

    assign conh_w[g] = {pls_q, dep_q, 1'b0, rty_q, pri_q};
    assign conl_w[g] = {5'h00, clr_q, send_q, 1'b0, is_tx, ie_q};
    assign idx_w[g] = is_tx ? tail : head;
    assign sta_w[g] = {3'h0, idx_w[g], abt_q, arb_q, err_q, flags};
    assign pls_w[g] = pls_q;
    assign pend_w[g] = send_q & is_tx & ~empty & ~abort_q & ~clr_q;
    assign pri_w[g*5 +: 5] = pri_q;
    assign irq_w[g] = |(flags & ie_q[4:0]);
    assign ts_w[g] = ts_q;
    assign abort_req[g] = abort_q;
  end

  wire logic pick_valid;
  wire logic [2:0] pick_chan;

  cfq_pick u_pick (
    .pend(pend_w),
    .pri(pri_w),
    .valid(pick_valid),
    .chan(pick_chan)
  );

  // Register read path
  wire logic [2:0] rd_ch = reg_addr[4:2];
  wire cfq_word_t rd_word = (reg_sel == CFQ_R_CONH) ? conh_w[rd_ch] :
                            (reg_sel == CFQ_R_CONL) ? conl_w[rd_ch] :
                            (reg_sel == CFQ_R_STA) ? sta_w[rd_ch] : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) reg_rdata <= 16'h0000;
    else reg_rdata <= reg_rd ? rd_word : 16'h0000;
  end

  // Next transmission toward the protocol engine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_chan <= 3'h0;
      tx_index <= 5'h00;
      tx_payload_bytes <= `CFQ_PL0;
    end else begin
      tx_valid <= pick_valid;
      tx_chan <= pick_chan;
      tx_index <= idx_w[pick_chan];
      tx_payload_bytes <= cfq_payload_bytes(pls_w[pick_chan]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
      rx_ts_capture <= 8'h00;
    end else begin
      irq <= |irq_w;
      rx_ts_capture <= ts_w;
    end
  end
endmodule : cfq_ctrl

// ---- testbench/cfq_ctrl_props.sv ----
`timescale 1ns/100ps
module cfq_ctrl_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0] eng_rx_store,
  input wire logic tx_valid,
  input wire logic [6:0] tx_payload_bytes,
  input wire logic [7:0] abort_req,
  input wire logic [7:0] rx_ts_capture,
  input wire logic irq
);
  wire logic [1:0] sel = reg_addr[1:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_low;
    reg_rd && sel == 2'h1;
  endsequence
  sequence s_rd_qsta;
    reg_rd && reg_addr == 5'h02;
  endsequence
  a_adv_reads0:
    assert property (s_rd_low |=> reg_rdata[15:11] == 5'h00 && !reg_rdata[8]) else $error("low bits");
  a_queue_dir:
    assert property (reg_rd && reg_addr == 5'h01 |=> reg_rdata[7] && !reg_rdata[6]) else $error("qdir");
  a_qsta_unused:
    assert property (s_rd_qsta |=> reg_rdata[15:13] == 3'h0 && !reg_rdata[3]) else $error("qsta bits");
  a_empty_notfull:
    assert property (s_rd_qsta |=> !reg_rdata[2] || reg_rdata[0]) else $error("empty and full");
  a_ts_cause:
    assert property (|rx_ts_capture |-> (rx_ts_capture & ~$past(eng_rx_store, 2)) == 8'h00) else $error("ts");
  a_payload_set:
    assert property (tx_valid |-> tx_payload_bytes inside {7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30,
      7'h40}) else $error("payload");
  a_abort_cause:
    assert property (|(abort_req & ~$past(abort_req)) |-> $past(reg_wr) && $past(sel) == 2'h1)
      else $error("abort cause");
  a_reset_idle:
    assert property ($fell(sys_rst) |-> !irq && !tx_valid && abort_req == 8'h00) else $error("reset");
endmodule : cfq_ctrl_chk
bind cfq_ctrl cfq_ctrl_chk i_cfq_ctrl_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_rx_store(eng_rx_store), .tx_valid(tx_valid),
  .tx_payload_bytes(tx_payload_bytes), .abort_req(abort_req), .rx_ts_capture(rx_ts_capture), .irq(irq));

// ---- testbench/cfq_eng_model.sv ----
`timescale 1ns/100ps
module cfq_eng_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic tx_valid,
  input wire logic [2:0] tx_chan,
  input wire logic [7:0] abort_req,
  input wire logic hold,
  input wire logic fail_mode,
  output logic [7:0] eng_tx_done,
  output logic [7:0] eng_abort_done,
  output logic [7:0] eng_attempt_fail,
  output logic [7:0] eng_lost_arb,
  output logic [7:0] eng_bus_err
);
  logic [1:0] gap_q;
  assign eng_lost_arb = eng_attempt_fail;
  assign eng_bus_err = eng_attempt_fail;
  // Spaced events let queue state settle
  always @(posedge sys_clk) begin
    eng_tx_done <= 8'h00;
    eng_abort_done <= 8'h00;
    eng_attempt_fail <= 8'h00;
    gap_q <= gap_q - {1'b0, gap_q != 2'h0};
    if (sys_rst) begin
      gap_q <= 2'h3;
    end else if (gap_q == 2'h0 && abort_req != 8'h00) begin
      eng_abort_done <= abort_req;
      gap_q <= 2'h3;
    end else if (gap_q == 2'h0 && tx_valid && !hold) begin
      if (fail_mode) eng_attempt_fail <= 8'h01 << tx_chan;
      else eng_tx_done <= 8'h01 << tx_chan;
      gap_q <= 2'h2;
    end
  end
endmodule : cfq_eng_model

// ---- testbench/tb_cfq_ctrl.sv ----
`timescale 1ns/100ps
module tb_cfq_ctrl;
  logic sys_clk, sys_rst, reg_wr, reg_rd, rle, tx_valid, irq, hold, fmode, rd_d;
  logic [2:0] mode, tx_chan;
  logic [4:0] reg_addr, tidx;
  logic [6:0] pl;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] exp_q[$];
  logic [7:0] done, abt, fail, arb, berr, rxs, rtr, abort_req, ts;
  logic [31:0] seed;
  int errors, n_tests, cyc, nfail, i;
  cfq_ctrl i_cfq_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .operating_mode_sel(mode),
    .retry_limit_enable(rle), .eng_tx_done(done), .eng_abort_done(abt), .eng_attempt_fail(fail),
    .eng_lost_arb(arb), .eng_bus_err(berr), .eng_rx_store(rxs), .eng_rx_rtr(rtr), .tx_valid(tx_valid),
    .tx_chan(tx_chan), .tx_index(tidx), .tx_payload_bytes(pl), .abort_req(abort_req), .rx_ts_capture(ts), .irq(irq));
  cfq_eng_model i_cfq_eng_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_chan(tx_chan),
    .abort_req(abort_req), .hold(hold), .fail_mode(fmode), .eng_tx_done(done), .eng_abort_done(abt),
    .eng_attempt_fail(fail), .eng_lost_arb(arb), .eng_bus_err(berr));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(0, 1, a, 16'h0000);
  endtask : rd
  task automatic drain;
    repeat (3) bus(0, 0, 5'h00, 16'h0000);
    for (i = 0; i < 99 && tx_valid !== 1'b0; i++)
      @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask : drain
  task automatic print_verdict;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (|fail) nfail <= nfail + 1;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end
  always @(negedge sys_clk)
    if (rd_d && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), reg_rdata);
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, rle, hold, fmode} = 5'h00;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    {rxs, rtr} = 16'h0000;
    mode = 3'h4;
    seed = 32'h0001_1609;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    nfail = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) bus(0, 0, 5'h00, 16'h0000);
    rd(5'h01, 16'h0080);
    rd(5'h02, 16'h0005);
    rd(5'h04, 16'h0060);
    rd(5'h05, 16'h0000);
    rd(5'h03, 16'h0000);
    mode <= 3'h0;
    bus(1, 0, 5'h00, 16'hff7f);
    rd(5'h00, 16'h007f);
    mode <= 3'h4;
    bus(1, 0, 5'h00, 16'he325);
    mode <= 3'h0;
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      bus(1, 0, 5'h00, {seed[15:8], 3'h1, seed[4:0]});
      rd(5'h00, {8'he3, 3'h1, seed[4:0]});
    end
    repeat (5) bus(1, 0, 5'h01, 16'h0100);
    rd(5'h02, 16'h0000);
    bus(1, 0, 5'h01, 16'h0200);
    repeat (2) bus(0, 0, 5'h00, 16'h0000);
    #1 chk("bytes", 16'h0040, {9'h000, pl});
    drain();
    rd(5'h01, 16'h0080);
    bus(1, 0, 5'h01, 16'h0100);
    bus(1, 0, 5'h01, 16'h0200);
    drain();
    rd(5'h02, 16'h0105);
    hold <= 1'b1;
    bus(1, 0, 5'h01, 16'h0100);
    bus(1, 0, 5'h01, 16'h0200);
    bus(1, 0, 5'h01, 16'h0000);
    drain();
    rd(5'h02, 16'h0181);
    rd(5'h02, 16'h0181);
    {hold, fmode, rle} <= 3'h3;
    bus(1, 0, 5'h01, 16'h0210);
    repeat (2) bus(0, 0, 5'h00, 16'h0000);
    #1 chk("index", 16'h0001, {8'h00, tx_chan, tidx});
    drain();
    #1 chk("irq", 16'h0001, {15'h0000, irq});
    chk("fails", 16'h0003, nfail[15:0]);
    rd(5'h02, 16'h01f1);
    bus(1, 0, 5'h02, 16'h0000);
    rd(5'h02, 16'h01e1);
    #1 chk("irq", 16'h0000, {15'h0000, irq});
    {fmode, rle} <= 2'h0;
    bus(1, 0, 5'h05, 16'h0228);
    rd(5'h05, 16'h0028);
    for (i = 0; i < 2; i++) begin
      rxs <= 8'h02;
      bus(0, 0, 5'h00, 16'h0000);
      rxs <= 8'h00;
      bus(0, 0, 5'h00, 16'h0000);
      #1 chk("ts", i ? 16'h0000 : 16'h0002, {8'h00, ts});
    end
    rd(5'h06, 16'h000f);
    #1 chk("irq", 16'h0001, {15'h0000, irq});
    bus(1, 0, 5'h05, 16'h0128);
    rd(5'h06, 16'h0008);
    hold <= 1'b1;
    bus(1, 0, 5'h05, 16'h00c0);
    rtr <= 8'h02;
    bus(0, 0, 5'h00, 16'h0000);
    rtr <= 8'h00;
    rd(5'h05, 16'h02c0);
    bus(1, 0, 5'h05, 16'h06c0);
    repeat (2) bus(0, 0, 5'h00, 16'h0000);
    rd(5'h05, 16'h00c0);
    rd(5'h06, 16'h0007);
    repeat (3) bus(0, 0, 5'h00, 16'h0000);
    print_verdict();
  end
endmodule : tb_cfq_ctrl
